// >>> inc/scsc_pkg.sv
package scsc_pkg;

  // ==========================================================================
  // Serial register frame
  // ==========================================================================
  localparam int          ADDR_W      = 15;
  localparam int          DATA_W      = 8;
  localparam logic [4:0]  FRAME_LAST  = 5'h17;
  localparam logic [4:0]  ADDR_LAST   = 5'h0f;
  localparam logic [4:0]  READ_FIRST  = 5'h10;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFS_SUPPLY_NOISE  = 15'h002b;
  localparam logic [ADDR_W-1:0] OFS_REPEAT_ON     = 15'h002c;
  localparam logic [ADDR_W-1:0] OFS_TRIGGER_CTRL  = 15'h002d;
  localparam logic [ADDR_W-1:0] OFS_AUX_SELECT    = 15'h002e;
  localparam logic [ADDR_W-1:0] OFS_VCO_DIVIDERS  = 15'h003d;
  localparam logic [ADDR_W-1:0] OFS_FEEDBACK_DIV  = 15'h003e;
  localparam logic [ADDR_W-1:0] OFS_HOLD_RESET    = 15'h005c;
  localparam logic [ADDR_W-1:0] OFS_TUNE_REQUEST  = 15'h005d;
  localparam logic [ADDR_W-1:0] OFS_TUNE_FINISHED = 15'h005e;
  localparam logic [ADDR_W-1:0] OFS_LOCK_FLAG     = 15'h0208;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int NOISE_ANALOG_BIT = 0;
  localparam int NOISE_CLOCK_BIT  = 1;
  localparam int PRESCALER_LSB    = 4;
  localparam int VDIV_LSB         = 0;
  localparam int FIELD4_W         = 4;
  localparam int TRIG_EN_BIT      = 7;
  localparam int TRIG_MODE_LSB    = 4;
  localparam int TRIG_DIV_LSB     = 0;
  localparam int AUX_OVR_BIT      = 7;
  localparam int AUX_D_BIT        = 4;
  localparam int AUX_C_LSB        = 0;
  localparam int AUX_C_W          = 3;
  localparam int INVALID_DIV_BIT  = 1;

  // ==========================================================================
  // Reset values and encodings
  // ==========================================================================
  localparam logic [7:0]   NOISE_RESET     = 8'h00;
  localparam logic [7:0]   VCO_DIV_RESET   = 8'h24;
  localparam logic [7:0]   FB_DIV_RESET    = 8'h04;
  localparam logic [7:0]   TRIG_RESET      = 8'h01;
  localparam logic [7:0]   AUX_RESET       = 8'h00;
  localparam logic [1:0]   TRIG_MODE_STAMP = 2'h3;
  localparam logic [2:0]   AUX_C_OFF       = 3'h0;
  localparam logic [2:0]   AUX_C_DIV1      = 3'h1;
  localparam logic [2:0]   AUX_C_DIV2      = 3'h2;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_MHZ         = 50;
  localparam int CAL_TIME_US_DEF = 20;

  typedef enum logic [1:0] {
    SCSC_IDLE = 2'b00,
    SCSC_CAL  = 2'b01,
    SCSC_DONE = 2'b10
  } scsc_cal_e;

  function automatic logic scsc_divisor_ok(input logic [7:0] prod);
    case (prod)
      8'h05, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h10: scsc_divisor_ok = 1'b1;
      default: scsc_divisor_ok = 1'b0;
    endcase
  endfunction

endpackage

// >>> inc/scsc_reg_if.sv
`timescale 1ns/1ps
interface scsc_reg_if;
  import scsc_pkg::*;
  logic              wr_stb;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport serial (output wr_stb, output addr, output wdata, input rdata);
  modport regs   (input wr_stb, input addr, input wdata, output rdata);
endinterface

// >>> logic/scsc_serial.sv
`timescale 1ns/1ps
module scsc_serial
  import scsc_pkg::*;
(
  // System
  input  wire logic  clk,
  input  wire logic  nrst,
  // Filtered serial pins
  input  wire logic  sclk_f,
  input  wire logic  cs_n_f,
  input  wire logic  sdi_f,
  output logic       sdo,
  output logic       sdo_oe,
  // Register side
  scsc_reg_if.serial bus
);

  // ==========================================================================
  // Frame decode
  // ==========================================================================
  logic        sclk_d;
  logic [4:0]  bit_cnt;
  logic [15:0] shift;
  logic        is_read;
  logic        load_rd;
  logic        wr_pend;
  logic [7:0]  rd_shift;
  logic        rise;
  logic        fall;

  assign rise = sclk_f & ~sclk_d;
  assign fall = ~sclk_f & sclk_d;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclk_d <= 1'b1;
    end else begin
      sclk_d <= sclk_f;
    end
  end

  // Bits past the last one of a frame are ignored, so an overlong frame is harmless.
  always_ff @(posedge clk) begin
    if (!nrst || cs_n_f) begin
      bit_cnt   <= 5'h00;
      shift     <= 16'h0000;
      is_read   <= 1'b0;
      load_rd   <= 1'b0;
      wr_pend   <= 1'b0;
      bus.addr  <= '0;
      bus.wdata <= '0;
    end else begin
      load_rd <= 1'b0;
      wr_pend <= 1'b0;
      if (rise && bit_cnt <= FRAME_LAST) begin
        shift   <= {shift[14:0], sdi_f};
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == ADDR_LAST) begin
          bus.addr <= {shift[13:0], sdi_f};
          is_read  <= shift[14];
          load_rd  <= shift[14];
        end
        if (bit_cnt == FRAME_LAST) begin
          bus.wdata <= {shift[6:0], sdi_f};
          wr_pend   <= ~is_read;
        end
      end
    end
  end

  assign bus.wr_stb = wr_pend;

  // Read data is captured one cycle after the address settles and leaves on falling edges.
  always_ff @(posedge clk) begin
    if (!nrst || cs_n_f) begin
      rd_shift <= 8'h00;
      sdo      <= 1'b0;
      sdo_oe   <= 1'b0;
    end else begin
      sdo_oe <= is_read && bit_cnt >= READ_FIRST;
      if (load_rd) begin
        rd_shift <= bus.rdata;
      end else if (fall && is_read && bit_cnt >= READ_FIRST && bit_cnt <= FRAME_LAST) begin
        sdo      <= rd_shift[7];
        rd_shift <= {rd_shift[6:0], 1'b0};
      end
    end
  end

  property p_oe_read_only;
    @(posedge clk) disable iff (!nrst)
    sdo_oe |-> $past(is_read) && !$past(cs_n_f);
  endproperty
  a_oe_read_only: assert property (p_oe_read_only) else $error("sdo driven outside a read");

  property p_write_once;
    @(posedge clk) disable iff (!nrst)
    bus.wr_stb |=> !bus.wr_stb;
  endproperty
  a_write_once: assert property (p_write_once) else $error("write strobe longer than a cycle");

endmodule

// >>> logic/scsc_top.sv
`timescale 1ns/1ps
// Function
// [RL1] Synth enabled only by strap, else direct clock.
// [RL2] Reference select pin picks differential or single-ended.
// [RL3] Rate equals ref times feedback, VCO over divisors.
// [RL4] Only divisor products 5,6,8,10,12,16 are valid.
// [RL5] Host bypasses synth for unsupported rates.
// [RL6] Host holds synth reset while changing settings.
// [RL7] Dividers held at 0x3d and 0x3e, writable.
// [RL8] Host requests calibration after programming dividers.
// [RL9] Calibration runs when hold reset is cleared.
// [RL10] Report calibration done and lock flags.
// [RL11] Supply noise control bits for analog, clock.
// [RL12] Repeat output copies the selected reference.
// [RL13] Repeat output auto on, software can disable.
// [RL14] Repeat output needs synth strap, no powerdown.
// [RL15] Trigger output from timestamp or lane clock.
// [RL16] Trigger output off at startup, software enables.
// [RL17] Lane source frequency is line rate over divider.
// [RL18] Aux outputs on from straps unless powerdown.
// [RL19] Register aux selects override the straps.
// [RL20] Straps set C divider, only enable for D.
// [RL21] Aux clock function beats over-range signalling.
// [RL22] Hold reset forces lock low, clears done.
module scsc_top
  import scsc_pkg::*;
#(
  parameter int CAL_TIME_US = CAL_TIME_US_DEF
)(
  // System
  input  wire logic       clk,
  input  wire logic       nrst,
  // Strap and control pins
  input  wire logic       synth_enable_pin,
  input  wire logic       ref_single_ended_select,
  input  wire logic       powerdown_pin,
  input  wire logic [1:0] clock_out_straps,
  input  wire logic       timestamp_input,
  // Clocks from pins and analog blocks
  input  wire logic       diff_clock_input,
  input  wire logic       single_ended_ref_input,
  input  wire logic       synth_vco_clock,
  input  wire logic       serial_lane_clock,
  input  wire logic       aux_c_clock_src,
  input  wire logic       aux_d_clock_src,
  // Over-range signalling
  input  wire logic       over_range_c,
  input  wire logic       over_range_d,
  // Analog synthesizer
  input  wire logic       synth_lock_raw,
  output logic            synth_active,
  output logic            synth_in_reset,
  output logic            osc_tune_running,
  output logic [3:0]      vco_prescaler,
  output logic [3:0]      vco_divider,
  output logic [7:0]      feedback_divider,
  output logic            noise_supp_analog,
  output logic            noise_supp_clock,
  output logic            synth_ref_clock,
  output logic            sampling_clock,
  // Clock outputs
  output logic            ref_repeat_out,
  output logic            ref_repeat_drive,
  output logic            trigger_clock_out,
  output logic            trigger_drive,
  output logic [3:0]      lane_divider,
  output logic            aux_clock_out_c,
  output logic            aux_clock_out_d,
  output logic            aux_c_is_clock,
  output logic            aux_d_is_clock,
  output logic [2:0]      aux_c_divider,
  // Serial register port
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sdi,
  output logic            spi_sdo,
  output logic            spi_sdo_oe
);

  localparam int          CAL_CYC  = CAL_TIME_US * CLK_MHZ;
  localparam logic [15:0] CAL_LAST = 16'(CAL_CYC - 1);
  localparam int          NPIN     = 10;
  // Serial clock and select idle high; their filters start there to avoid a false frame.
  localparam logic [NPIN-1:0] PIN_IDLE = {2'b11, {(NPIN-2){1'b0}}};

  // ==========================================================================
  // Pin filtering
  // ==========================================================================
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] st1;
  logic [NPIN-1:0] st2;
  logic [NPIN-1:0] st3;
  logic [NPIN-1:0] pin_f;

  assign pin_raw = {spi_sclk, spi_cs_n, spi_sdi, synth_enable_pin, ref_single_ended_select,
                    powerdown_pin, clock_out_straps, timestamp_input, synth_lock_raw};

  // A change is taken only once the last two stages agree, which also rejects single glitches.
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!nrst) begin
        st1[i]   <= PIN_IDLE[i];
        st2[i]   <= PIN_IDLE[i];
        st3[i]   <= PIN_IDLE[i];
        pin_f[i] <= PIN_IDLE[i];
      end else begin
        st1[i] <= pin_raw[i];
        st2[i] <= st1[i];
        st3[i] <= st2[i];
        if (st2[i] == st3[i]) begin
          pin_f[i] <= st3[i];
        end
      end
    end
  end

  logic       sclk_f;
  logic       cs_n_f;
  logic       sdi_f;
  logic       synth_en_f;
  logic       ref_se_f;
  logic       pd_f;
  logic [1:0] straps_f;
  logic       stamp_f;
  logic       lock_f;

  assign {sclk_f, cs_n_f, sdi_f, synth_en_f, ref_se_f, pd_f, straps_f, stamp_f, lock_f} = pin_f;

  // ==========================================================================
  // Register port
  // ==========================================================================
  scsc_reg_if bus ();

  scsc_serial u_serial (
    .clk    (clk),
    .nrst   (nrst),
    .sclk_f (sclk_f),
    .cs_n_f (cs_n_f),
    .sdi_f  (sdi_f),
    .sdo    (spi_sdo),
    .sdo_oe (spi_sdo_oe),
    .bus    (bus.serial)
  );

  logic [7:0] noise_reg;
  logic [7:0] vco_div_reg;
  logic [7:0] fb_div_reg;
  logic [7:0] trig_reg;
  logic [7:0] aux_reg;
  logic       repeat_on;
  logic       hold_reset;
  logic       tune_request;
  logic       tune_done;
  logic       lock_flag;
  logic       div_ok;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      noise_reg   <= NOISE_RESET;
      vco_div_reg <= VCO_DIV_RESET;
      fb_div_reg  <= FB_DIV_RESET;
      trig_reg    <= TRIG_RESET;
      aux_reg     <= AUX_RESET;
    end else if (bus.wr_stb) begin
      case (bus.addr)
        OFS_SUPPLY_NOISE: noise_reg   <= bus.wdata; // [RL11]
        OFS_VCO_DIVIDERS: vco_div_reg <= bus.wdata; // [RL7]
        OFS_FEEDBACK_DIV: fb_div_reg  <= bus.wdata; // [RL7]
        OFS_TRIGGER_CTRL: trig_reg    <= bus.wdata; // [RL16]
        OFS_AUX_SELECT:   aux_reg     <= bus.wdata; // [RL19]
        default: ;
      endcase
    end
  end

  // Repeat output defaults on, so a strapped system has its reference with no software.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      repeat_on    <= 1'b1;
      hold_reset   <= 1'b0;
      tune_request <= 1'b0;
    end else if (bus.wr_stb) begin
      if (bus.addr == OFS_REPEAT_ON) repeat_on <= bus.wdata[0]; // [RL13]
      if (bus.addr == OFS_HOLD_RESET) hold_reset <= bus.wdata[0];
      if (bus.addr == OFS_TUNE_REQUEST) tune_request <= bus.wdata[0];
    end
  end

  always_comb begin
    bus.rdata = 8'h00;
    case (bus.addr)
      OFS_SUPPLY_NOISE:  bus.rdata = noise_reg;
      OFS_REPEAT_ON:     bus.rdata = {7'h00, repeat_on};
      OFS_TRIGGER_CTRL:  bus.rdata = trig_reg;
      OFS_AUX_SELECT:    bus.rdata = aux_reg;
      OFS_VCO_DIVIDERS:  bus.rdata = vco_div_reg;
      OFS_FEEDBACK_DIV:  bus.rdata = fb_div_reg;
      OFS_HOLD_RESET:    bus.rdata = {7'h00, hold_reset};
      OFS_TUNE_REQUEST:  bus.rdata = {7'h00, tune_request};
      OFS_TUNE_FINISHED: bus.rdata = {6'h00, ~div_ok, tune_done}; // [RL10] [RL4]
      OFS_LOCK_FLAG:     bus.rdata = {7'h00, lock_flag}; // [RL10]
      default:           bus.rdata = 8'h00;
    endcase
  end

  // ==========================================================================
  // Synthesizer control and calibration
  // ==========================================================================
  scsc_cal_e   cal_state;
  logic [15:0] cal_cnt;
  logic        hold_d;
  logic        cal_pend;

  assign vco_prescaler    = vco_div_reg[PRESCALER_LSB +: FIELD4_W]; // [RL3]
  assign vco_divider      = vco_div_reg[VDIV_LSB +: FIELD4_W]; // [RL3]
  assign feedback_divider = fb_div_reg; // [RL3]
  assign div_ok = scsc_divisor_ok(8'(vco_prescaler * vco_divider)); // [RL4]
  assign synth_active      = synth_en_f; // [RL1]
  assign synth_in_reset    = hold_reset | ~synth_en_f;
  assign osc_tune_running  = cal_state == SCSC_CAL;
  assign noise_supp_analog = noise_reg[NOISE_ANALOG_BIT]; // [RL11]
  assign noise_supp_clock  = noise_reg[NOISE_CLOCK_BIT]; // [RL11]
  assign synth_ref_clock   = ref_se_f ? single_ended_ref_input : diff_clock_input; // [RL2]
  assign sampling_clock    = synth_en_f ? synth_vco_clock : diff_clock_input; // [RL1]

  // Leaving reset counts as a release, so a strapped part tunes itself at power-up.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hold_d   <= 1'b0;
      cal_pend <= 1'b1;
    end else begin
      hold_d <= hold_reset;
      if (hold_d && !hold_reset && tune_request) begin
        cal_pend <= 1'b1; // [RL9]
      end else if (cal_state == SCSC_CAL) begin
        cal_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cal_state <= SCSC_IDLE;
      cal_cnt   <= 16'h0000;
      tune_done <= 1'b0;
    end else if (hold_reset || !synth_en_f) begin
      cal_state <= SCSC_IDLE; // [RL22]
      cal_cnt   <= 16'h0000;
      tune_done <= 1'b0;
    end else begin
      case (cal_state)
        SCSC_IDLE: begin
          if (cal_pend && div_ok) cal_state <= SCSC_CAL; // [RL9]
        end
        SCSC_CAL: begin
          cal_cnt <= cal_cnt + 16'h0001;
          if (cal_cnt == CAL_LAST) begin
            cal_state <= SCSC_DONE;
            tune_done <= 1'b1; // [RL10]
          end
        end
        SCSC_DONE: begin
          if (cal_pend) begin
            cal_state <= SCSC_IDLE;
            cal_cnt   <= 16'h0000;
            tune_done <= 1'b0;
          end
        end
        default: cal_state <= SCSC_IDLE;
      endcase
    end
  end

  assign lock_flag = tune_done & lock_f & ~hold_reset; // [RL10] [RL22]

  // ==========================================================================
  // Clock outputs
  // ==========================================================================
  logic [2:0] strap_c;
  logic       strap_d;
  logic [2:0] sel_c;
  logic       sel_d;

  always_comb begin
    strap_c = AUX_C_OFF;
    strap_d = 1'b0;
    case (straps_f) // [RL20]
      2'b01:   strap_c = AUX_C_DIV1;
      2'b10:   begin strap_c = AUX_C_DIV2; strap_d = 1'b1; end
      2'b11:   begin strap_c = AUX_C_DIV1; strap_d = 1'b1; end
      default: strap_c = AUX_C_OFF;
    endcase
    sel_c = aux_reg[AUX_OVR_BIT] ? aux_reg[AUX_C_LSB +: AUX_C_W] : strap_c; // [RL19]
    sel_d = aux_reg[AUX_OVR_BIT] ? aux_reg[AUX_D_BIT] : strap_d; // [RL19]
  end

  // Output D is only offered while C runs, since both share one divided reference.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref_repeat_drive <= 1'b0;
      trigger_drive    <= 1'b0;
      lane_divider     <= 4'h0;
      aux_c_is_clock   <= 1'b0;
      aux_d_is_clock   <= 1'b0;
      aux_c_divider    <= AUX_C_OFF;
    end else begin
      ref_repeat_drive <= repeat_on & synth_en_f & ~pd_f; // [RL13] [RL14]
      trigger_drive    <= trig_reg[TRIG_EN_BIT]; // [RL16]
      lane_divider     <= trig_reg[TRIG_DIV_LSB +: FIELD4_W]; // [RL17]
      aux_c_is_clock   <= (sel_c != AUX_C_OFF) & ~pd_f; // [RL18]
      aux_d_is_clock   <= sel_d & (sel_c != AUX_C_OFF) & ~pd_f; // [RL18] [RL20]
      aux_c_divider    <= sel_c; // [RL20]
    end
  end

  assign ref_repeat_out  = ref_repeat_drive & synth_ref_clock; // [RL12]
  assign trigger_clock_out = trigger_drive &
    ((trig_reg[TRIG_MODE_LSB +: 2] == TRIG_MODE_STAMP) ? stamp_f : serial_lane_clock); // [RL15]
  assign aux_clock_out_c = aux_c_is_clock ? aux_c_clock_src : over_range_c; // [RL21]
  assign aux_clock_out_d = aux_d_is_clock ? aux_d_clock_src : over_range_d; // [RL21]

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_hold_lock;
    @(posedge clk) disable iff (!nrst)
    hold_reset |-> !lock_flag ##1 !tune_done;
  endproperty
  a_hold_lock: assert property (p_hold_lock) else $error("lock or done under hold"); // [RL22]

  property p_cal_start;
    @(posedge clk) disable iff (!nrst)
    $fell(hold_reset) && tune_request && div_ok && synth_en_f |-> ##[1:3] osc_tune_running;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration did not start"); // [RL9]

  property p_done_after_cal;
    @(posedge clk) disable iff (!nrst)
    $rose(tune_done) |-> $past(cal_cnt) == CAL_LAST && $past(osc_tune_running);
  endproperty
  a_done_after_cal: assert property (p_done_after_cal) else $error("done without full cal"); // [RL10]

  property p_bad_divisor;
    @(posedge clk) disable iff (!nrst)
    !div_ok && cal_state == SCSC_IDLE |=> cal_state == SCSC_IDLE;
  endproperty
  a_bad_divisor: assert property (p_bad_divisor) else $error("cal on invalid divisor"); // [RL4]

  property p_repeat_pd;
    @(posedge clk) disable iff (!nrst)
    pd_f || !synth_en_f || !repeat_on |=> !ref_repeat_drive;
  endproperty
  a_repeat_pd: assert property (p_repeat_pd) else $error("repeat output on wrongly"); // [RL14]

  property p_div_write;
    @(posedge clk) disable iff (!nrst)
    bus.wr_stb && bus.addr == OFS_VCO_DIVIDERS |=>
      {vco_prescaler, vco_divider} == $past(bus.wdata);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divider write lost"); // [RL7]

  property p_trig_off;
    @(posedge clk) disable iff (!nrst)
    !trig_reg[TRIG_EN_BIT] |=> !trigger_drive && !trigger_clock_out;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger out while disabled"); // [RL16]

  property p_d_needs_c;
    @(posedge clk) disable iff (!nrst)
    aux_d_is_clock |-> aux_c_is_clock && aux_c_divider != AUX_C_OFF;
  endproperty
  a_d_needs_c: assert property (p_d_needs_c) else $error("output D without C"); // [RL20]

  property p_aux_pd;
    @(posedge clk) disable iff (!nrst)
    pd_f |=> !aux_c_is_clock && aux_clock_out_c == over_range_c;
  endproperty
  a_aux_pd: assert property (p_aux_pd) else $error("aux clock under powerdown"); // [RL18]

endmodule

// >>> testbench/scsc_clock_sink.sv
`timescale 1ns/1ps
module scsc_clock_sink (
  // Clocks from the device
  input  wire logic ref_repeat_out,
  input  wire logic trigger_clock_out,
  input  wire logic aux_clock_out_c,
  input  wire logic aux_clock_out_d,
  // Count control
  input  wire logic clr,
  output int        n_ref,
  output int        n_trig,
  output int        n_c,
  output int        n_d
);
  // ==========================================================================
  // Edge counters
  // ==========================================================================
  // Counting edges rather than sampling levels shows that a clock really runs.
  always @(posedge ref_repeat_out or posedge clr) n_ref <= clr ? 0 : n_ref + 1;
  always @(posedge trigger_clock_out or posedge clr) n_trig <= clr ? 0 : n_trig + 1;
  always @(posedge aux_clock_out_c or posedge clr) n_c <= clr ? 0 : n_c + 1;
  always @(posedge aux_clock_out_d or posedge clr) n_d <= clr ? 0 : n_d + 1;
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import scsc_pkg::*;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
  // ==========================================================================
  // Stimulus and observed signals
  // ==========================================================================
  logic clk = 0, nrst = 0, synth_enable_pin = 1, ref_single_ended_select = 0;
  logic powerdown_pin = 0, timestamp_input = 0, diff_clock_input = 0;
  logic single_ended_ref_input = 0, synth_vco_clock = 0, serial_lane_clock = 0;
  logic aux_c_clock_src = 0, aux_d_clock_src = 0, over_range_c = 0, over_range_d = 1;
  logic synth_lock_raw = 1, spi_sclk = 1, spi_cs_n = 1, spi_sdi = 0, clr = 0;
  logic [1:0] clock_out_straps = 2'h0;
  logic synth_active, synth_in_reset, osc_tune_running, noise_supp_analog;
  logic noise_supp_clock, synth_ref_clock, sampling_clock, ref_repeat_out;
  logic ref_repeat_drive, trigger_clock_out, trigger_drive, aux_clock_out_c;
  logic aux_clock_out_d, aux_c_is_clock, aux_d_is_clock, spi_sdo, spi_sdo_oe;
  logic [3:0] vco_prescaler, vco_divider, lane_divider;
  logic [7:0] feedback_divider, rd;
  logic [2:0] aux_c_divider;
  logic [7:0] tbl [7] = '{8'h15, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h28, 8'h27};
  int         checks = 0, n_fail = 0, n_ref, n_trig, n_c, n_d;

  always #10 clk = ~clk;
  always #4 synth_vco_clock = ~synth_vco_clock;
  always #15 diff_clock_input = ~diff_clock_input;
  always #35 single_ended_ref_input = ~single_ended_ref_input;
  always #25 serial_lane_clock = ~serial_lane_clock;
  always #45 aux_c_clock_src = ~aux_c_clock_src;
  always #55 aux_d_clock_src = ~aux_d_clock_src;

  scsc_top #(.CAL_TIME_US(1)) uut (.*);
  scsc_clock_sink sink (.ref_repeat_out(ref_repeat_out), .trigger_clock_out(trigger_clock_out),
    .aux_clock_out_c(aux_clock_out_c), .aux_clock_out_d(aux_clock_out_d), .clr(clr),
    .n_ref(n_ref), .n_trig(n_trig), .n_c(n_c), .n_d(n_d));

  // ==========================================================================
  // Serial access tasks
  // ==========================================================================
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Half periods of 8 clocks leave room for the 3-stage pin filter.
  task automatic spi(input logic rw, input logic [14:0] a, input logic [7:0] d);
    logic [23:0] f;
    f = {rw, a, d};
    @(posedge clk) spi_cs_n <= 0;
    wait_clk(4);
    for (int i = 23; i >= 0; i--) begin
      spi_sclk <= 0;
      spi_sdi <= f[i];
      wait_clk(8);
      if (i < 8) rd[i] = spi_sdo;
      if (i == 0 && rw) `CHK("sdo_oe", 1'b1, spi_sdo_oe)
      spi_sclk <= 1;
      wait_clk(8);
    end
    spi_cs_n <= 1;
    wait_clk(10);
    `CHK("oe_idle", 1'b0, spi_sdo_oe)
  endtask

  task automatic rchk(input string nm, input logic [14:0] a, input logic [7:0] e);
    spi(1'b1, a, 8'h00);
    `CHK(nm, e, rd)
  endtask

  task automatic window();
    wait_clk(6);
    clr <= 1;
    wait_clk(1);
    clr <= 0;
    wait_clk(100);
  endtask

  task close_out;
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    wait_clk(40000);
    n_fail++;
    close_out();
  end

  initial begin
    wait_clk(5);
    nrst <= 1;
    wait_clk(12);
    rchk("noise", OFS_SUPPLY_NOISE, 8'h00);
    rchk("vdiv", OFS_VCO_DIVIDERS, 8'h24);
    rchk("fdiv", OFS_FEEDBACK_DIV, 8'h04);
    rchk("trig", OFS_TRIGGER_CTRL, 8'h01);
    rchk("unmapped", 15'h0100, 8'h00);
    rchk("done", OFS_TUNE_FINISHED, 8'h01);
    rchk("lock", OFS_LOCK_FLAG, 8'h01);
    `CHK("trig_drive", 1'b0, trigger_drive)
    `CHK("rep_drive", 1'b1, ref_repeat_drive)
    #1;
    `CHK("samp", synth_vco_clock, sampling_clock)
    window();
    `CHK("rep_diff", 1'b1, n_ref > 50)
    ref_single_ended_select <= 1;
    window();
    `CHK("rep_se", 1'b1, n_ref > 20 && n_ref < 35)
    spi(1'b0, OFS_REPEAT_ON, 8'h00);
    `CHK("rep_off", 1'b0, ref_repeat_drive)
    spi(1'b0, OFS_REPEAT_ON, 8'h01);
    powerdown_pin <= 1;
    clock_out_straps <= 2'h2;
    wait_clk(8);
    `CHK("rep_pd", 1'b0, ref_repeat_drive)
    `CHK("aux_pd", 1'b0, aux_c_is_clock)
    powerdown_pin <= 0;
    window();
    `CHK("aux_c", 3'h2, aux_c_divider)
    `CHK("aux_cd", 2'h3, {aux_c_is_clock, aux_d_is_clock})
    `CHK("aux_run", 1'b1, n_c > 10 && n_d > 10)
    clock_out_straps <= 2'h1;
    wait_clk(8);
    `CHK("aux_c1", 3'h1, aux_c_divider)
    `CHK("aux_d_or", over_range_d, aux_clock_out_d)
    spi(1'b0, OFS_AUX_SELECT, 8'h92);
    `CHK("ovr", 4'ha, {aux_d_is_clock, aux_c_divider})
    spi(1'b0, OFS_TRIGGER_CTRL, 8'h85);
    `CHK("lane", 5'h15, {trigger_drive, lane_divider})
    window();
    `CHK("trig_lane", 1'b1, n_trig > 35 && n_trig < 45)
    spi(1'b0, OFS_TRIGGER_CTRL, 8'hb0);
    timestamp_input <= 1;
    wait_clk(8);
    `CHK("trig_ts", 1'b1, trigger_clock_out)
    timestamp_input <= 0;
    wait_clk(8);
    `CHK("trig_ts0", 1'b0, trigger_clock_out)
    spi(1'b0, OFS_SUPPLY_NOISE, 8'h03);
    `CHK("noise_out", 2'h3, {noise_supp_clock, noise_supp_analog})
    spi(1'b0, OFS_HOLD_RESET, 8'h01);
    `CHK("in_reset", 1'b1, synth_in_reset)
    rchk("lock_hold", OFS_LOCK_FLAG, 8'h00);
    rchk("done_hold", OFS_TUNE_FINISHED, 8'h00);
    for (int k = 0; k < 7; k++) begin
      spi(1'b0, OFS_VCO_DIVIDERS, tbl[k]);
      rchk("divisor", OFS_TUNE_FINISHED, {6'h0, k == 6, 1'b0});
    end
    spi(1'b0, OFS_VCO_DIVIDERS, 8'h25);
    `CHK("pv", 8'h25, {vco_prescaler, vco_divider})
    spi(1'b0, OFS_FEEDBACK_DIV, 8'h0a);
    `CHK("n", 8'h0a, feedback_divider)
    spi(1'b0, OFS_TUNE_REQUEST, 8'h01);
    spi(1'b0, OFS_HOLD_RESET, 8'h00);
    `CHK("cal_run", 1'b1, osc_tune_running)
    wait_clk(60);
    rchk("done2", OFS_TUNE_FINISHED, 8'h01);
    rchk("lock2", OFS_LOCK_FLAG, 8'h01);
    synth_enable_pin <= 0;
    wait_clk(8);
    `CHK("synth_off", 2'h0, {synth_active, ref_repeat_drive})
    #1;
    `CHK("samp_direct", diff_clock_input, sampling_clock)
    rchk("lock_off", OFS_LOCK_FLAG, 8'h00);
    close_out();
  end
endmodule
